// ---- hw/iosrd_decoder.sv ----
// I/O space register decoder: instruction-port decode, bit access and register bank
// Functional notes
// RULE1: Registers at I/O 0x00..0x1F can be set or cleared one bit at a time and single bits there can be tested.
// RULE2: Set-bit and clear-bit operations above I/O 0x1F do nothing.
// RULE3: A set-bit or clear-bit operation writes only the addressed bit and never clears other pending flags.
// RULE4: Flag bits clear when written with one and stay unchanged when written with zero.
// RULE5: Dedicated port read and write operations decode I/O addresses 0x00..0x3F.
// RULE6: A memory access at I/O address plus 0x20 reaches the same register as the I/O access.
// RULE7: The extended range 0x60..0xFF is reached only by memory reads and writes, never by port operations.
// RULE8: Software should write zero to reserved bits it touches.
// RULE9: Software never writes reserved I/O addresses.
// RULE10: Timer flags hold overflow at bit 0, match A at bit 1, match B at bit 2 and timer1 capture at bit 5.
// RULE11: Reserved bits and addresses read zero and writes to them have no effect.
`timescale 1ns/1ns
`default_nettype none
module iosrd_decoder (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire iosrd_pkg::iosrd_op_s   op_i,
    input  wire iosrd_pkg::iosrd_evt_s  evt_i,
    input  wire iosrd_pkg::iosrd_stat_s stat_i,
    output logic [7:0]                 rdata_o,
    output logic                       rvalid_o,
    output logic                       skip_o,
    output logic                       ext_access_o,
    output iosrd_pkg::iosrd_bank_t      io_regs_o
);
    import iosrd_pkg::*;

    iosrd_bank_t regs_q;
    iosrd_bank_t regs_d;
    iosrd_bank_t ro_val;
    iosrd_bank_t set_ev;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic        skip_q;
    logic        skip_d;
    logic        ext_q;
    logic        ext_d;

    logic        is_io;
    logic        is_mem;
    logic        is_bit;
    logic        is_skip;
    logic        is_read;
    logic        is_write;
    logic        hit;
    logic        ext_hit;
    logic [5:0]  idx;
    logic [7:0]  mem_off;
    logic [7:0]  onehot;
    logic [7:0]  wen_bits;
    logic [7:0]  wval;
    logic [7:0]  cur;

    assign mem_off = op_i.addr - MEM_IO_BASE;
    assign onehot  = BIT_ONE << op_i.bit_sel;

    // Decode of instruction class and target register
    always_comb begin
        is_io    = op_i.valid && (op_i.kind == IO_READ_OP || op_i.kind == IO_WRITE_OP);
        is_mem   = op_i.valid && (op_i.kind == MEMORY_READ_FAMILY || op_i.kind == MEMORY_WRITE_FAMILY);
        is_bit   = op_i.valid && (op_i.kind == SET_BIT_OP || op_i.kind == CLEAR_BIT_OP);
        is_skip  = op_i.valid && (op_i.kind == SKIP_IF_BIT_SET_OP || op_i.kind == SKIP_IF_BIT_CLEAR_OP);
        is_read  = op_i.kind == IO_READ_OP || op_i.kind == MEMORY_READ_FAMILY;
        is_write = op_i.kind == IO_WRITE_OP || op_i.kind == MEMORY_WRITE_FAMILY;
        hit      = 1'b0;
        idx      = op_i.addr[5:0];
        ext_hit  = is_mem && (op_i.addr >= MEM_EXT_BASE); // [RULE7]
        if (is_io && op_i.addr <= IO_TOP) begin // [RULE5] [RULE7]
            hit = 1'b1;
        end else if (is_mem && op_i.addr >= MEM_IO_BASE && op_i.addr < MEM_EXT_BASE) begin
            hit = 1'b1;
            idx = mem_off[5:0]; // [RULE6]
        end else if ((is_bit || is_skip) && op_i.addr <= BIT_IO_TOP) begin // [RULE1] [RULE2]
            hit = 1'b1;
        end
    end

    // Write lanes: a full write covers the byte, a bit operation only its bit
    always_comb begin
        wen_bits = BYTE_ZERO;
        wval     = BYTE_ZERO;
        if (hit && is_write) begin
            wen_bits = BYTE_ONES;
            wval     = op_i.wdata;
        end else if (hit && is_bit) begin
            wen_bits = onehot; // [RULE3]
            wval     = (op_i.kind == SET_BIT_OP) ? onehot : BYTE_ZERO;
        end
    end

    // Hardware status bits that software only reads
    always_comb begin
        ro_val                              = '0;
        ro_val[ADDR_B_PINS]                 = stat_i.pins_b;
        ro_val[ADDR_C_PINS]                 = stat_i.pins_c;
        ro_val[ADDR_D_PINS]                 = stat_i.pins_d;
        ro_val[ADDR_E_PINS][2:0]            = stat_i.pins_e;
        ro_val[ADDR_PLL_CS][PLL_LOCK_BIT]   = stat_i.pll_lock;
        ro_val[ADDR_SPI_STAT][SPI_FLAG_BIT] = stat_i.spi_flag;
        ro_val[ADDR_SPI_STAT][SPI_COLL_BIT] = stat_i.spi_collide;
    end

    // Peripheral events raising sticky flags
    always_comb begin
        set_ev                                = '0;
        set_ev[ADDR_TMR0_FLAGS][TOV_BIT]      = evt_i.tmr0[0]; // [RULE10]
        set_ev[ADDR_TMR0_FLAGS][MATCH_A_BIT]  = evt_i.tmr0[1];
        set_ev[ADDR_TMR0_FLAGS][MATCH_B_BIT]  = evt_i.tmr0[2];
        set_ev[ADDR_TMR1_FLAGS][TOV_BIT]      = evt_i.tmr1[0]; // [RULE10]
        set_ev[ADDR_TMR1_FLAGS][MATCH_A_BIT]  = evt_i.tmr1[1];
        set_ev[ADDR_TMR1_FLAGS][MATCH_B_BIT]  = evt_i.tmr1[2];
        set_ev[ADDR_TMR1_FLAGS][CAPTURE_BIT]  = evt_i.tmr1[3];
        set_ev[ADDR_PC_FLAGS][3:0]            = evt_i.pin_change;
        set_ev[ADDR_EXT_FLAGS][3:0]           = evt_i.ext_irq;
    end

    // Per-register next value; a flag event wins over a clear in the same cycle
    for (genvar g = 0; g < IO_REGS; g++) begin : g_reg
        localparam logic [5:0] IDX = 6'(g);
        localparam logic [7:0] RW  = iosrd_rw_mask(IDX);
        localparam logic [7:0] WC  = iosrd_w1c_mask(IDX);
        logic [7:0] lane;
        logic [7:0] kept;
        assign lane = (hit && idx == IDX) ? wen_bits : BYTE_ZERO;
        assign kept = (regs_q[g] & ~(RW & lane)) | (wval & RW & lane);
        assign regs_d[g] = ((kept & ~(WC & lane & wval)) | (set_ev[g] & WC)) & (RW | WC); // [RULE4] [RULE11]
    end

    // Read value, skip test and extended-range notice
    always_comb begin
        cur      = (regs_q[idx] & (iosrd_rw_mask(idx) | iosrd_w1c_mask(idx)))
                 | (ro_val[idx] & ~iosrd_rw_mask(idx) & ~iosrd_w1c_mask(idx)); // [RULE11]
        rvalid_d = (is_io || is_mem) && is_read;
        rdata_d  = (hit && is_read) ? cur : BYTE_ZERO;
        skip_d   = hit && is_skip && (cur[op_i.bit_sel] == (op_i.kind == SKIP_IF_BIT_SET_OP)); // [RULE1]
        ext_d    = ext_hit;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regs_q   <= {IO_REGS{IO_RESET}};
            rdata_q  <= BYTE_ZERO;
            rvalid_q <= 1'b0;
            skip_q   <= 1'b0;
            ext_q    <= 1'b0;
        end else begin
            regs_q   <= regs_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            skip_q   <= skip_d;
            ext_q    <= ext_d;
        end
    end

    assign rdata_o      = rdata_q;
    assign rvalid_o     = rvalid_q;
    assign skip_o       = skip_q;
    assign ext_access_o = ext_q;
    assign io_regs_o    = regs_q;

    // Checks
    logic no_evt;
    assign no_evt = (evt_i == '0);

    property p_bit_only;
        @(posedge clk_i) disable iff (rst_i)
        (hit && is_bit && no_evt) |=>
            (((regs_q[$past(idx)] ^ $past(regs_q[idx])) & ~$past(onehot)) == BYTE_ZERO);
    endproperty
    a_bit_only: assert property (p_bit_only) else $error("bit op touched other bits"); // [RULE3]

    property p_bit_high;
        @(posedge clk_i) disable iff (rst_i)
        (is_bit && op_i.addr > BIT_IO_TOP && no_evt) |=> (regs_q == $past(regs_q));
    endproperty
    a_bit_high: assert property (p_bit_high) else $error("bit op above range changed bank"); // [RULE2]

    property p_set_bit;
        @(posedge clk_i) disable iff (rst_i)
        (hit && op_i.kind == SET_BIT_OP && op_i.addr[5:0] == ADDR_B_OUT) |=>
            regs_q[ADDR_B_OUT][$past(op_i.bit_sel)];
    endproperty
    a_set_bit: assert property (p_set_bit) else $error("set bit failed"); // [RULE1]

    property p_skip;
        @(posedge clk_i) disable iff (rst_i)
        (hit && op_i.kind == SKIP_IF_BIT_CLEAR_OP && !cur[op_i.bit_sel]) |=> skip_o;
    endproperty
    a_skip: assert property (p_skip) else $error("skip on clear bit missed"); // [RULE1]

    property p_w1c;
        @(posedge clk_i) disable iff (rst_i)
        (hit && is_write && idx == ADDR_TMR0_FLAGS && no_evt) |=>
            (regs_q[ADDR_TMR0_FLAGS] == ($past(regs_q[ADDR_TMR0_FLAGS]) & ~$past(op_i.wdata)));
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag write-one-clear wrong"); // [RULE4]

    property p_io_range;
        @(posedge clk_i) disable iff (rst_i)
        (is_io && is_write && op_i.addr > IO_TOP && no_evt) |=> $stable(regs_q);
    endproperty
    a_io_range: assert property (p_io_range) else $error("port write beyond 0x3F acted"); // [RULE5]

    property p_alias;
        @(posedge clk_i) disable iff (rst_i)
        (op_i.valid && op_i.kind == MEMORY_WRITE_FAMILY && op_i.addr == (MEM_IO_BASE + {2'b00, ADDR_GP_STORE0})) |=>
            (regs_q[ADDR_GP_STORE0] == $past(op_i.wdata));
    endproperty
    a_alias: assert property (p_alias) else $error("data-space alias missed"); // [RULE6]

    property p_ext;
        @(posedge clk_i) disable iff (rst_i)
        (ext_hit && no_evt) |=> (ext_access_o && rdata_o == BYTE_ZERO && $stable(regs_q));
    endproperty
    a_ext: assert property (p_ext) else $error("extended access mishandled"); // [RULE7]

    property p_capture;
        @(posedge clk_i) disable iff (rst_i)
        evt_i.tmr1[3] |=> regs_q[ADDR_TMR1_FLAGS][CAPTURE_BIT];
    endproperty
    a_capture: assert property (p_capture) else $error("capture flag not at bit 5"); // [RULE10]

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i)
        (hit && is_read && idx == 6'h00) |=> (rdata_o == BYTE_ZERO);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address read nonzero"); // [RULE11]

    // A flag event in the cycle of its clear must survive
    property p_evt_wins;
        @(posedge clk_i) disable iff (rst_i)
        (hit && is_write && idx == ADDR_EXT_FLAGS && evt_i.ext_irq[0]) |=> regs_q[ADDR_EXT_FLAGS][0];
    endproperty
    a_evt_wins: assert property (p_evt_wins) else $error("flag event lost to clear"); // [RULE4]

    property p_rvalid;
        @(posedge clk_i) disable iff (rst_i)
        rvalid_o |-> ($past(op_i.valid) && $past(is_read));
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read valid without read"); // [RULE5]

    property p_mem_low;
        @(posedge clk_i) disable iff (rst_i)
        (is_mem && is_write && op_i.addr < MEM_IO_BASE && no_evt) |=> $stable(regs_q);
    endproperty
    a_mem_low: assert property (p_mem_low) else $error("memory write below window acted"); // [RULE6]

    c_bit_flag: cover property (@(posedge clk_i) disable iff (rst_i)
        hit && op_i.kind == SET_BIT_OP && idx == ADDR_TMR1_FLAGS);
    c_mem_read: cover property (@(posedge clk_i) disable iff (rst_i)
        hit && is_mem && is_read);
    c_skip: cover property (@(posedge clk_i) disable iff (rst_i) skip_o);
    c_race: cover property (@(posedge clk_i) disable iff (rst_i)
        hit && is_write && idx == ADDR_EXT_FLAGS && evt_i.ext_irq != 4'h0);
endmodule
`default_nettype wire

// ---- inc/iosrd_pkg.sv ----
// Constants, types and register map for the I/O space register decoder
package iosrd_pkg;
    localparam int IO_REGS = 64;
    localparam logic [7:0] IO_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hFF;
    localparam logic [7:0] BIT_ONE = 8'h01;
    // Address windows
    localparam logic [7:0] BIT_IO_TOP = 8'h1F;
    localparam logic [7:0] IO_TOP = 8'h3F;
    localparam logic [7:0] MEM_IO_BASE = 8'h20;
    localparam logic [7:0] MEM_EXT_BASE = 8'h60;
    // I/O register indices
    localparam logic [5:0] ADDR_B_PINS = 6'h03;
    localparam logic [5:0] ADDR_B_DIR = 6'h04;
    localparam logic [5:0] ADDR_B_OUT = 6'h05;
    localparam logic [5:0] ADDR_C_PINS = 6'h06;
    localparam logic [5:0] ADDR_C_DIR = 6'h07;
    localparam logic [5:0] ADDR_C_OUT = 6'h08;
    localparam logic [5:0] ADDR_D_PINS = 6'h09;
    localparam logic [5:0] ADDR_D_DIR = 6'h0A;
    localparam logic [5:0] ADDR_D_OUT = 6'h0B;
    localparam logic [5:0] ADDR_E_PINS = 6'h0C;
    localparam logic [5:0] ADDR_E_DIR = 6'h0D;
    localparam logic [5:0] ADDR_E_OUT = 6'h0E;
    localparam logic [5:0] ADDR_TMR0_FLAGS = 6'h15;
    localparam logic [5:0] ADDR_TMR1_FLAGS = 6'h16;
    localparam logic [5:0] ADDR_GP_STORE1 = 6'h19;
    localparam logic [5:0] ADDR_GP_STORE2 = 6'h1A;
    localparam logic [5:0] ADDR_PC_FLAGS = 6'h1B;
    localparam logic [5:0] ADDR_EXT_FLAGS = 6'h1C;
    localparam logic [5:0] ADDR_EXT_MASK = 6'h1D;
    localparam logic [5:0] ADDR_GP_STORE0 = 6'h1E;
    localparam logic [5:0] ADDR_EE_CTRL = 6'h1F;
    localparam logic [5:0] ADDR_EE_DATA = 6'h20;
    localparam logic [5:0] ADDR_EE_ADDR_LO = 6'h21;
    localparam logic [5:0] ADDR_EE_ADDR_HI = 6'h22;
    localparam logic [5:0] ADDR_TMR_GEN = 6'h23;
    localparam logic [5:0] ADDR_TMR0_CTRL_A = 6'h24;
    localparam logic [5:0] ADDR_TMR0_CTRL_B = 6'h25;
    localparam logic [5:0] ADDR_TMR0_COUNT = 6'h26;
    localparam logic [5:0] ADDR_TMR0_CMP_A = 6'h27;
    localparam logic [5:0] ADDR_TMR0_CMP_B = 6'h28;
    localparam logic [5:0] ADDR_PLL_CS = 6'h29;
    localparam logic [5:0] ADDR_SPI_CTRL = 6'h2C;
    localparam logic [5:0] ADDR_SPI_STAT = 6'h2D;
    // Field positions
    localparam int TOV_BIT = 0;
    localparam int MATCH_A_BIT = 1;
    localparam int MATCH_B_BIT = 2;
    localparam int CAPTURE_BIT = 5;
    localparam int PLL_LOCK_BIT = 0;
    localparam int SPI_FLAG_BIT = 7;
    localparam int SPI_COLL_BIT = 6;

    typedef enum logic [7:0] {
        IO_READ_OP           = 8'h01,
        IO_WRITE_OP          = 8'h02,
        MEMORY_READ_FAMILY   = 8'h04,
        MEMORY_WRITE_FAMILY  = 8'h08,
        SET_BIT_OP           = 8'h10,
        CLEAR_BIT_OP         = 8'h20,
        SKIP_IF_BIT_SET_OP   = 8'h40,
        SKIP_IF_BIT_CLEAR_OP = 8'h80
    } iosrd_kind_e;

    typedef struct packed {
        logic        valid;
        iosrd_kind_e kind;
        logic [7:0]  addr;
        logic [2:0]  bit_sel;
        logic [7:0]  wdata;
    } iosrd_op_s;

    typedef struct packed {
        logic [2:0] tmr0;
        logic [3:0] tmr1;
        logic [3:0] pin_change;
        logic [3:0] ext_irq;
    } iosrd_evt_s;

    typedef struct packed {
        logic [7:0] pins_b;
        logic [7:0] pins_c;
        logic [7:0] pins_d;
        logic [2:0] pins_e;
        logic       pll_lock;
        logic       spi_flag;
        logic       spi_collide;
    } iosrd_stat_s;

    typedef logic [IO_REGS-1:0][7:0] iosrd_bank_t;

    function automatic logic [7:0] iosrd_rw_mask(input logic [5:0] idx);
        case (idx)
            ADDR_B_DIR, ADDR_B_OUT, ADDR_C_DIR, ADDR_C_OUT,
            ADDR_D_DIR, ADDR_D_OUT, ADDR_GP_STORE0, ADDR_GP_STORE1,
            ADDR_GP_STORE2, ADDR_EE_DATA, ADDR_EE_ADDR_LO,
            ADDR_TMR0_COUNT, ADDR_TMR0_CMP_A, ADDR_TMR0_CMP_B,
            ADDR_SPI_CTRL: return 8'hFF;
            ADDR_E_DIR, ADDR_E_OUT: return 8'h07;
            ADDR_EXT_MASK, ADDR_EE_CTRL: return 8'h0F;
            ADDR_EE_ADDR_HI: return 8'h03;
            ADDR_TMR_GEN: return 8'hC1;
            ADDR_TMR0_CTRL_A: return 8'hF3;
            ADDR_TMR0_CTRL_B: return 8'h0F;
            ADDR_PLL_CS: return 8'h06;
            ADDR_SPI_STAT: return 8'h01;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] iosrd_w1c_mask(input logic [5:0] idx);
        case (idx)
            ADDR_TMR0_FLAGS: return 8'h07;
            ADDR_TMR1_FLAGS: return 8'h27;
            ADDR_PC_FLAGS, ADDR_EXT_FLAGS: return 8'h0F;
            default: return 8'h00;
        endcase
    endfunction
endpackage

// ---- sim/iosrd_core_model.sv ----
// Processor core model that issues I/O, memory and bit operations to the decoder
`timescale 1ns/1ns
`default_nettype none
module iosrd_core_model (
    input  wire logic                clk_i,
    input  wire logic [7:0]          rdata_i,
    input  wire logic                rvalid_i,
    input  wire logic                skip_i,
    input  wire logic                ext_i,
    output var  iosrd_pkg::iosrd_op_s op_o
);
    import iosrd_pkg::*;

    initial op_o = '0;

    function automatic bit is_reserved(input logic [5:0] a);
        return a inside {[6'h00:6'h02], [6'h0F:6'h14], 6'h17, 6'h18, 6'h2A, 6'h2B};
    endfunction

    // One op per call, or none for a write to a reserved address; results are sampled just after the taking edge, where they stand
    task automatic issue(input iosrd_kind_e k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] wd,
                         output logic [7:0] rd, output logic rv, output logic sk, output logic ea);
        logic       hit;
        logic [5:0] io;
        rd = 8'h00;
        rv = 1'b0;
        sk = 1'b0;
        ea = 1'b0;
        hit = (k == IO_WRITE_OP) ? (a <= 8'h3F) : ((k == MEMORY_WRITE_FAMILY) && (a inside {[8'h20:8'h5F]}));
        io = (k == MEMORY_WRITE_FAMILY) ? 6'(a - 8'h20) : a[5:0];
        if (hit && is_reserved(io)) begin
            return;
        end
        @(posedge clk_i);
        op_o <= '{valid: 1'b1, kind: k, addr: a, bit_sel: b, wdata: wd};
        @(posedge clk_i);
        op_o.valid <= 1'b0;
        #1;
        rd = rdata_i;
        rv = rvalid_i;
        sk = skip_i;
        ea = ext_i;
    endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking testbench for the I/O space register decoder
`timescale 1ns/1ns
`default_nettype none
module tb;
    import iosrd_pkg::*;
    logic        clk_i;
    logic        rst_i;
    iosrd_op_s   op_i;
    iosrd_evt_s  evt_i;
    iosrd_stat_s stat_i;
    logic [7:0]  rdata_o;
    logic        rvalid_o;
    logic        skip_o;
    logic        ext_access_o;
    iosrd_bank_t io_regs_o;
    int          bad_count;
    int          check_count;
    logic [7:0]  rd;
    logic        rv;
    logic        sk;
    logic        ea;

    iosrd_decoder u_iosrd_decoder (.clk_i(clk_i), .rst_i(rst_i), .op_i(op_i), .evt_i(evt_i), .stat_i(stat_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .skip_o(skip_o), .ext_access_o(ext_access_o),
        .io_regs_o(io_regs_o));
    iosrd_core_model u_iosrd_core_model (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
        .skip_i(skip_o), .ext_i(ext_access_o), .op_o(op_i));

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic op(input iosrd_kind_e k, input logic [7:0] a, input logic [2:0] b, input logic [7:0] wd);
        u_iosrd_core_model.issue(k, a, b, wd, rd, rv, sk, ea);
    endtask

    task automatic t_reset;
        chk8("port_b_output after reset", 8'h00, io_regs_o[5'h05]);
        op(IO_READ_OP, 8'h1E, 3'h0, 8'h00);
        chk1("read valid", 1'b1, rv);
        chk8("gp store 0 after reset", 8'h00, rd);
    endtask

    task automatic t_alias;
        op(IO_WRITE_OP, 8'h05, 3'h0, 8'hA5);
        chk8("port_b_output port write", 8'hA5, io_regs_o[6'h05]);
        op(MEMORY_READ_FAMILY, 8'h25, 3'h0, 8'h00);
        chk8("port_b_output memory read", 8'hA5, rd);
        op(MEMORY_WRITE_FAMILY, 8'h3E, 3'h0, 8'h5A);
        op(IO_READ_OP, 8'h1E, 3'h0, 8'h00);
        chk8("gp store 0 alias", 8'h5A, rd);
        op(IO_WRITE_OP, 8'h45, 3'h0, 8'hFF);
        chk8("port_b_output after port write above 3F", 8'hA5, io_regs_o[6'h05]);
    endtask

    task automatic t_bits;
        op(SET_BIT_OP, 8'h05, 3'h3, 8'h00);
        chk8("port_b_output set bit 3", 8'hAD, io_regs_o[6'h05]);
        op(CLEAR_BIT_OP, 8'h05, 3'h0, 8'h00);
        chk8("port_b_output clear bit 0", 8'hAC, io_regs_o[6'h05]);
        op(SKIP_IF_BIT_SET_OP, 8'h05, 3'h2, 8'h00);
        chk1("skip set bit 2", 1'b1, sk);
        op(SKIP_IF_BIT_CLEAR_OP, 8'h05, 3'h2, 8'h00);
        chk1("skip clear bit 2", 1'b0, sk);
        op(SKIP_IF_BIT_CLEAR_OP, 8'h05, 3'h0, 8'h00);
        chk1("skip clear bit 0", 1'b1, sk);
        // Reserved bits of timer0 control A written as zero
        op(IO_WRITE_OP, 8'h24, 3'h0, 8'h03);
        op(CLEAR_BIT_OP, 8'h24, 3'h0, 8'h00);
        chk8("timer0 ctrl a clear bit", 8'h03, io_regs_o[6'h24]);
        op(SET_BIT_OP, 8'h24, 3'h7, 8'h00);
        chk8("timer0 ctrl a set bit", 8'h03, io_regs_o[6'h24]);
        op(SKIP_IF_BIT_SET_OP, 8'h24, 3'h0, 8'h00);
        chk1("skip above 1F", 1'b0, sk);
    endtask

    task automatic t_flags;
        @(posedge clk_i);
        evt_i <= '{tmr0: 3'h7, tmr1: 4'hF, pin_change: 4'hF, ext_irq: 4'hF};
        @(posedge clk_i);
        evt_i <= '0;
        #1;
        chk8("timer0 flags", 8'h07, io_regs_o[6'h15]);
        chk8("timer1 flags", 8'h27, io_regs_o[6'h16]);
        chk8("external flags", 8'h0F, io_regs_o[6'h1C]);
        op(IO_WRITE_OP, 8'h15, 3'h0, 8'h02);
        chk8("timer0 flags one written", 8'h05, io_regs_o[6'h15]);
        op(SET_BIT_OP, 8'h16, 3'h0, 8'h00);
        chk8("timer1 set bit on flag", 8'h26, io_regs_o[6'h16]);
        op(CLEAR_BIT_OP, 8'h16, 3'h1, 8'h00);
        chk8("timer1 clear bit on flag", 8'h26, io_regs_o[6'h16]);
        op(MEMORY_WRITE_FAMILY, 8'h3B, 3'h0, 8'h00);
        chk8("pin change flags zero written", 8'h0F, io_regs_o[6'h1B]);
        op(IO_READ_OP, 8'h16, 3'h0, 8'h00);
        chk8("timer1 flags read", 8'h26, rd);
        fork
            op(IO_WRITE_OP, 8'h1C, 3'h0, 8'h0F);
            begin
                @(posedge clk_i);
                evt_i <= '{tmr0: 3'h0, tmr1: 4'h0, pin_change: 4'h0, ext_irq: 4'h1};
                @(posedge clk_i);
                evt_i <= '0;
            end
        join
        chk8("external flag event beats clear", 8'h01, io_regs_o[6'h1C]);
    endtask

    task automatic t_ext;
        op(MEMORY_READ_FAMILY, 8'h60, 3'h0, 8'h00);
        chk1("extended access", 1'b1, ea);
        chk8("extended read data", 8'h00, rd);
        op(IO_READ_OP, 8'h03, 3'h0, 8'h00);
        chk8("port b pins", 8'h3C, rd);
        op(IO_READ_OP, 8'h0C, 3'h0, 8'h00);
        chk8("port e pins", 8'h05, rd);
        op(IO_WRITE_OP, 8'h03, 3'h0, 8'hFF);
        chk8("port b pins not stored", 8'h00, io_regs_o[6'h03]);
        op(IO_READ_OP, 8'h00, 3'h0, 8'h00);
        chk8("reserved address read", 8'h00, rd);
        op(MEMORY_READ_FAMILY, 8'h10, 3'h0, 8'h00);
        chk8("memory read below 20", 8'h00, rd);
        chk1("no extended access", 1'b0, ea);
        op(IO_READ_OP, 8'h2D, 3'h0, 8'h00);
        chk8("spi status", 8'hC0, rd);
        op(MEMORY_READ_FAMILY, 8'h49, 3'h0, 8'h00);
        chk8("pll status alias", 8'h01, rd);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        rst_i = 1'b1;
        evt_i = '0;
        stat_i = '{pins_b: 8'h3C, pins_c: 8'h81, pins_d: 8'h00, pins_e: 3'h5, pll_lock: 1'b1, spi_flag: 1'b1,
                   spi_collide: 1'b1};
        bad_count = 0;
        check_count = 0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_alias();
        t_bits();
        t_flags();
        t_ext();
        end_sim();
    end

    // About 29 ops of two cycles each; this leaves a wide margin
    initial begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        end_sim();
    end
endmodule
`default_nettype wire
